/* File: include/tmcc_defs.vh */
`ifndef TMCC_DEFS_VH
`define TMCC_DEFS_VH

// --------------------------------------------------------------------
// register offsets (byte addresses, one word each)
// --------------------------------------------------------------------
`define TMCC_REG_CTRL 8'h00
`define TMCC_REG_KEY 8'h04
`define TMCC_REG_STATUS 8'h08
`define TMCC_REG_CODE 8'h0C
`define TMCC_REG_ADDR24 8'h10
`define TMCC_REG_REPLY 8'h14

// --------------------------------------------------------------------
// ctrl fields
// --------------------------------------------------------------------
`define TMCC_CTRL_ON_GROUND 0
`define TMCC_CTRL_RESTORE 1

// --------------------------------------------------------------------
// key command codes (written to the key register)
// --------------------------------------------------------------------
`define TMCC_KEY_DIGIT0 5'h00
`define TMCC_KEY_DIGIT7 5'h07
`define TMCC_KEY_DIGIT8 5'h08
`define TMCC_KEY_DIGIT9 5'h09
`define TMCC_KEY_MENU 5'h0A
`define TMCC_KEY_STANDBY 5'h0B
`define TMCC_KEY_ON 5'h0C
`define TMCC_KEY_ALT 5'h0D
`define TMCC_KEY_GND 5'h0E
`define TMCC_KEY_VFR 5'h0F
`define TMCC_KEY_CODE 5'h10
`define TMCC_KEY_IDENT 5'h11
`define TMCC_KEY_BACK 5'h12
`define TMCC_KEY_DIGIT_BACK 5'h13
`define TMCC_KEY_KNOB_DIGIT 5'h14
`define TMCC_KEY_KNOB_NEXT 5'h15
`define TMCC_KEY_CONFIRM 5'h16
`define TMCC_KEY_CANCEL 5'h17
`define TMCC_KEY_KNOB_PRESS 5'h18

// --------------------------------------------------------------------
// reply request codes
// --------------------------------------------------------------------
`define TMCC_REQ_MODE_A 2'h0
`define TMCC_REQ_MODE_C 2'h1
`define TMCC_REQ_MODE_S 2'h2
`define TMCC_REQ_MODE_S_ALT 2'h3

// --------------------------------------------------------------------
// operating modes
// --------------------------------------------------------------------
`define TMCC_MODE_GND 2'h0
`define TMCC_MODE_STANDBY_KEY 2'h1
`define TMCC_MODE_ON 2'h2
`define TMCC_MODE_ALT 2'h3

// --------------------------------------------------------------------
// reset values and timing
// --------------------------------------------------------------------
`define TMCC_VFR_CODE 12'h280
`define TMCC_CLK_HZ 200000000
`define TMCC_DIGIT_TIMEOUT_S 10
`define TMCC_KEYPAD_ACT_S 5
`define TMCC_KNOB_ACT_S 10
`define TMCC_MENU_TIMEOUT_S 45
`define TMCC_IDENT_S 5'h12
`define TMCC_SQUITTER_S 1
`define TMCC_REPLY_SHOW_S 1

`endif

/* File: tb/tb.sv */
`timescale 1ns/1ps
`include "tmcc_defs.vh"
`define CHECK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module tb;
    localparam CLK_HZ = 20;
    localparam [23:0] ICAO_ADDR = 24'h3C5A96; // arbitrary value
    logic clk_in = 1'h0, rst_b_in = 1'h0, wb_cyc_in = 1'h0, wb_stb_in = 1'h0, wb_we_in = 1'h0;
    logic on_ground_in = 1'h0, fire = 1'h0, wb_ack_out, interrogation_in, reply_valid_out;
    logic squitter_out, display_white_out, identify_indication_out;
    logic [7:0] wb_adr_in = 8'h00;
    logic [3:0] wb_sel_in = 4'h0;
    logic [31:0] wb_dat_in = 32'h0, wb_dat_out, rdata;
    logic [1:0] retained_mode_in = 2'h0, kind = 2'h0, interrogation_type_in, mode_out, menu_level_out;
    logic [12:0] pressure_alt_in = 13'h0, reply_alt_out;
    logic [11:0] old_c, new_c;
    logic [2:0] d[4];
    int num_errors = 0, num_checks = 0, sq_n = 0;
    always #2.5 clk_in = ~clk_in;
    always @(posedge clk_in) if (squitter_out === 1'b1) sq_n++;
    tmcc_core #(.CLK_HZ(CLK_HZ), .ICAO_ADDR(ICAO_ADDR)) tmcc_core_inst (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
        .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
        .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .on_ground_in(on_ground_in),
        .retained_mode_in(retained_mode_in), .interrogation_in(interrogation_in),
        .interrogation_type_in(interrogation_type_in), .pressure_alt_in(pressure_alt_in),
        .reply_valid_out(reply_valid_out), .reply_type_out(), .reply_alt_out(reply_alt_out),
        .reply_code_out(), .reply_has_alt_out(), .squitter_out(squitter_out), .squitter_addr_out(),
        .ident_tx_out(), .mode_out(mode_out), .display_white_out(display_white_out),
        .identify_indication_out(identify_indication_out), .reply_status_out(),
        .menu_level_out(menu_level_out));
    tmcc_interrogator tmcc_interrogator_inst (.clk_in(clk_in), .fire_in(fire), .kind_in(kind),
        .interrogation_out(interrogation_in), .type_out(interrogation_type_in));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dat);
        int n = 0;
        wb_cyc_in <= 1'h1;
        wb_stb_in <= 1'h1;
        wb_we_in <= we;
        wb_adr_in <= a;
        wb_sel_in <= 4'hF;
        wb_dat_in <= dat;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (wb_ack_out !== 1'b1 && n < 50);
        `CHECK(wb_ack_out, 1'b1)
        rdata = wb_dat_out;
        wb_cyc_in <= 1'h0;
        wb_stb_in <= 1'h0;
        @(posedge clk_in);
    endtask
    task automatic key(input logic [4:0] k, input logic [2:0] v = 3'h0);
        wb(1'h1, `TMCC_REG_KEY, {21'h0, v, 3'h0, k});
    endtask
    task automatic sel(input logic [4:0] k);
        key(`TMCC_KEY_MENU);
        key(k);
    endtask
    task automatic wait_s(input int s);
        repeat (s * CLK_HZ) @(posedge clk_in);
    endtask
    task automatic code_chk(input logic [11:0] p, input logic [11:0] a);
        wb(1'h0, `TMCC_REG_CODE, 32'h0);
        `CHECK(rdata[23:12], p)
        `CHECK(rdata[11:0], a)
    endtask
    function automatic logic exp_reply(input logic [1:0] m, input logic [1:0] t);
        case (m)
            `TMCC_MODE_GND: return t[1];
            `TMCC_MODE_ON: return t != `TMCC_REQ_MODE_C;
            `TMCC_MODE_ALT: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
    task automatic ask(input logic [1:0] t);
        logic [12:0] altitude_report_mode = 13'($urandom);
        logic got = 1'b0;
        pressure_alt_in <= altitude_report_mode;
        kind <= t;
        fire <= 1'h1;
        @(posedge clk_in);
        fire <= 1'h0;
        repeat (10)
        begin
            @(posedge clk_in);
            got = got | (reply_valid_out === 1'b1);
        end
        `CHECK(got, exp_reply(mode_out, t))
        if (got && t[0] && mode_out === `TMCC_MODE_ALT)
            `CHECK(reply_alt_out, altitude_report_mode)
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(42));
        retained_mode_in = `TMCC_MODE_ALT;
        repeat (10) @(posedge clk_in);
        rst_b_in <= 1'h1;
        repeat (2) @(posedge clk_in);
        `CHECK(mode_out, `TMCC_MODE_ALT)
        wb(1'h0, 8'h1C, 32'h0);
        `CHECK(rdata, 32'h0)
        wb(1'h0, `TMCC_REG_ADDR24, 32'h0);
        `CHECK(rdata[23:0], ICAO_ADDR)
        ask(`TMCC_REQ_MODE_C);
        repeat (4) ask(2'($urandom));
        sq_n = 0;
        wait_s(5);
        `CHECK(sq_n inside {[4:6]}, 1'b1)
        sel(`TMCC_KEY_ON);
        `CHECK(mode_out, `TMCC_MODE_ON)
        ask(`TMCC_REQ_MODE_A);
        repeat (4) ask(2'($urandom));
        sel(`TMCC_KEY_STANDBY);
        `CHECK({mode_out, display_white_out}, {`TMCC_MODE_STANDBY_KEY, 1'b1})
        repeat (4) ask(2'($urandom));
        key(`TMCC_KEY_IDENT);
        `CHECK(identify_indication_out, 1'b0)
        // keypad entry in standby
        sel(`TMCC_KEY_CODE);
        key(`TMCC_KEY_BACK);
        `CHECK(menu_level_out, 2'h1)
        key(`TMCC_KEY_CODE);
        `CHECK(menu_level_out, 2'h2)
        foreach (d[i]) d[i] = 3'($urandom);
        key({2'h0, d[0]});
        key(`TMCC_KEY_DIGIT8);
        key(`TMCC_KEY_DIGIT9);
        key({2'h0, ~d[1]});
        key(`TMCC_KEY_DIGIT_BACK);
        for (int i = 1; i < 4; i++) key({2'h0, d[i]});
        new_c = {d[0], d[1], d[2], d[3]};
        code_chk(new_c, 12'h000);
        wait_s(3);
        code_chk(new_c, 12'h000);
        wait_s(3);
        code_chk(new_c, new_c);
        old_c = new_c;
        key({2'h0, ~d[0]});
        key({2'h0, ~d[1]});
        wait_s(12);
        code_chk(old_c, old_c);
        // knob entry and aborts
        foreach (d[i]) d[i] = 3'($urandom);
        for (int i = 0; i < 4; i++)
        begin
            key(`TMCC_KEY_KNOB_DIGIT, d[i]);
            if (i < 3) key(`TMCC_KEY_KNOB_NEXT);
        end
        new_c = {d[0], d[1], d[2], d[3]};
        key(`TMCC_KEY_CONFIRM);
        wait_s(6);
        code_chk(new_c, old_c);
        wait_s(6);
        code_chk(new_c, new_c);
        for (int i = 0; i < 2; i++)
        begin
            key(`TMCC_KEY_KNOB_DIGIT, ~d[0]);
            key(i ? `TMCC_KEY_KNOB_PRESS : `TMCC_KEY_CANCEL);
            code_chk(new_c, new_c);
        end
        key(`TMCC_KEY_BACK);
        sel(`TMCC_KEY_ON);
        key(`TMCC_KEY_CODE);
        key(`TMCC_KEY_IDENT);
        `CHECK({menu_level_out, identify_indication_out}, 3'h1)
        wait_s(16);
        `CHECK(identify_indication_out, 1'b1)
        wait_s(3);
        `CHECK(identify_indication_out, 1'b0)
        sel(`TMCC_KEY_VFR);
        code_chk(`TMCC_VFR_CODE, `TMCC_VFR_CODE);
        key(`TMCC_KEY_VFR);
        code_chk(new_c, new_c);
        key(`TMCC_KEY_BACK);
        `CHECK(menu_level_out, 2'h0)
        key(`TMCC_KEY_MENU);
        wait_s(43);
        `CHECK(menu_level_out, 2'h1)
        wait_s(3);
        `CHECK(menu_level_out, 2'h0)
        // second reset, then ground handling
        retained_mode_in <= `TMCC_MODE_ON;
        rst_b_in <= 1'h0;
        @(posedge clk_in);
        rst_b_in <= 1'h1;
        repeat (4) @(posedge clk_in);
        `CHECK(mode_out, `TMCC_MODE_ON)
        on_ground_in <= 1'h1;
        repeat (6) @(posedge clk_in);
        `CHECK(mode_out, `TMCC_MODE_GND)
        ask(`TMCC_REQ_MODE_S);
        repeat (4) ask(2'($urandom));
        sel(`TMCC_KEY_STANDBY);
        `CHECK(mode_out, `TMCC_MODE_STANDBY_KEY)
        key(`TMCC_KEY_GND);
        `CHECK(mode_out, `TMCC_MODE_GND)
        on_ground_in <= 1'h0;
        repeat (6) @(posedge clk_in);
        `CHECK(mode_out, `TMCC_MODE_ALT)
        end_of_test();
    end
    initial
    begin
        repeat (8000) @(posedge clk_in);
        num_errors++;
        end_of_test();
    end
endmodule
bind tmcc_core tmcc_core_asserts #(.CLK_HZ(CLK_HZ), .ICAO_ADDR(ICAO_ADDR)) tmcc_core_asserts_inst (.*);

/* File: tb/tmcc_core_asserts.sv */
`timescale 1ns/1ps
`include "tmcc_defs.vh"
module tmcc_core_asserts #(
    parameter CLK_HZ = 20,
    parameter [23:0] ICAO_ADDR = 24'h000000
) (
    input wire clk_in,
    input wire rst_b_in,
    input wire wb_we_in,
    input wire wb_ack_out,
    input wire interrogation_in,
    input wire [1:0] interrogation_type_in,
    input wire [12:0] pressure_alt_in,
    input wire reply_valid_out,
    input wire [1:0] reply_type_out,
    input wire [12:0] reply_alt_out,
    input wire reply_has_alt_out,
    input wire squitter_out,
    input wire [23:0] squitter_addr_out,
    input wire ident_tx_out,
    input wire [1:0] mode_out,
    input wire display_white_out,
    input wire identify_indication_out,
    input wire reply_status_out,
    input wire [1:0] menu_level_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    int sq_gap_ff;
    int idle_ff;
    int id_len_ff;
    always @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sq_gap_ff <= 0;
            idle_ff <= 0;
            id_len_ff <= 0;
        end
        else
        begin
            sq_gap_ff <= squitter_out ? 0 : sq_gap_ff + 1;
            idle_ff <= (menu_level_out == 2'h0 || (wb_ack_out && wb_we_in)) ? 0 : idle_ff + 1;
            id_len_ff <= identify_indication_out ? id_len_ff + 1 : 0;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    AST_GND_NO_AC: assert property (reply_valid_out && mode_out == `TMCC_MODE_GND |-> reply_type_out[1])
        else $error("mode A or C reply in ground mode");
    AST_SQUIT_PERIOD: assert property (sq_gap_ff <= CLK_HZ + 1)
        else $error("squitter gap too long");
    AST_SQUIT_ADDR: assert property (squitter_out |-> squitter_addr_out == ICAO_ADDR)
        else $error("squitter address wrong");
    AST_STANDBY_KEY_SILENT: assert property (reply_valid_out |-> mode_out != `TMCC_MODE_STANDBY_KEY)
        else $error("reply in standby");
    AST_STANDBY_KEY_NO_IDENT: assert property (ident_tx_out || $rose(identify_indication_out)
        |-> mode_out != `TMCC_MODE_STANDBY_KEY)
        else $error("ident in standby");
    AST_ON_NO_ALT: assert property (reply_valid_out && mode_out == `TMCC_MODE_ON
        |-> !reply_has_alt_out && reply_type_out != `TMCC_REQ_MODE_C)
        else $error("altitude reported in on mode");
    AST_ON_ANSWERS: assert property ($rose(interrogation_in) && interrogation_type_in == `TMCC_REQ_MODE_A
        && mode_out == `TMCC_MODE_ON |-> ##[2:4] reply_valid_out)
        else $error("no mode A reply in on mode");
    AST_ALT_FILL: assert property (reply_valid_out && mode_out == `TMCC_MODE_ALT && reply_type_out[0]
        |-> reply_has_alt_out && reply_alt_out == pressure_alt_in)
        else $error("altitude missing from reply");
    AST_MENU_FALLBACK: assert property (idle_ff <= 46 * CLK_HZ)
        else $error("menu stayed low too long");
    AST_IDENT_SHOWN: assert property (ident_tx_out |-> ##[0:1] identify_indication_out)
        else $error("ident without indication");
    AST_IDENT_LEN: assert property (id_len_ff <= 19 * CLK_HZ)
        else $error("ident indication too long");
    AST_REPLY_STATUS: assert property (reply_valid_out |-> ##[1:2] reply_status_out)
        else $error("reply status not shown");
    AST_WHITE: assert property (display_white_out == (mode_out == `TMCC_MODE_STANDBY_KEY))
        else $error("display colour wrong");
    AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    cover property (reply_valid_out && mode_out == `TMCC_MODE_ALT);
    cover property ($fell(identify_indication_out));
    cover property (menu_level_out != 2'h0 ##1 menu_level_out == 2'h0);
endmodule

/* File: tb/tmcc_interrogator.sv */
`timescale 1ns/1ps
module tmcc_interrogator (
    input wire clk_in,
    input wire fire_in,
    input wire [1:0] kind_in,
    output logic interrogation_out,
    output logic [1:0] type_out
);
    int hold = 0;
    initial interrogation_out = 1'h0;
    initial type_out = 2'h0;
    // ------------------------------------------------------------
    // stretched past the two-stage synchroniser
    // ------------------------------------------------------------
    always @(posedge clk_in)
    begin
        if (fire_in)
        begin
            type_out <= kind_in;
            hold <= 6;
        end
        else if (hold != 0)
            hold <= hold - 1;
        interrogation_out <= (hold > 1);
    end
endmodule

/* File: verilog/tmcc_core.v */
// --------------------------------------------------------------------
// --------------------------------------------------------------------
`timescale 1ns/1ps
`include "tmcc_defs.vh"

module tmcc_core #(
    parameter CLK_HZ = `TMCC_CLK_HZ,
    parameter [23:0] ICAO_ADDR = 24'hABCDE1, // arbitrary value
    parameter [11:0] VFR_CODE = `TMCC_VFR_CODE
) (
    input wire clk_in,
    input wire rst_b_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output reg [31:0] wb_dat_out,
    output reg wb_ack_out,
    input wire on_ground_in,
    input wire [1:0] retained_mode_in,
    input wire interrogation_in,
    input wire [1:0] interrogation_type_in,
    input wire [12:0] pressure_alt_in,
    output reg reply_valid_out,
    output reg [1:0] reply_type_out,
    output reg [12:0] reply_alt_out,
    output reg [11:0] reply_code_out,
    output reg reply_has_alt_out,
    output reg squitter_out,
    output wire [23:0] squitter_addr_out,
    output reg ident_tx_out,
    output reg [1:0] mode_out,
    output wire display_white_out,
    output reg identify_indication_out,
    output reg reply_status_out,
    output reg [1:0] menu_level_out
);

// --------------------------------------------------------------------
// seconds tick and synchronisers
// --------------------------------------------------------------------
localparam [31:0] TICK_MAX = CLK_HZ - 1;
reg [31:0] div_ff;
reg sec_tick_ff;
always @(posedge clk_in or negedge rst_b_in)
begin
    if (!rst_b_in)
    begin
        div_ff <= 32'h00000000;
        sec_tick_ff <= 1'b0;
    end
    else
    begin
        sec_tick_ff <= (div_ff == TICK_MAX);
        div_ff <= (div_ff == TICK_MAX) ? 32'h00000000 : div_ff + 32'h00000001;
    end
end

reg gnd_s1_ff;
reg gnd_s2_ff;
reg gnd_prev_ff;
reg irq_s1_ff;
reg irq_s2_ff;
reg irq_prev_ff;
reg [1:0] settle_ff;
always @(posedge clk_in or negedge rst_b_in)
begin
    if (!rst_b_in)
    begin
        gnd_s1_ff <= 1'b1;
        gnd_s2_ff <= 1'b1;
        gnd_prev_ff <= 1'b1;
        irq_s1_ff <= 1'b0;
        irq_s2_ff <= 1'b0;
        irq_prev_ff <= 1'b0;
        settle_ff <= 2'h0;
    end
    else
    begin
        gnd_s1_ff <= on_ground_in;
        gnd_s2_ff <= gnd_s1_ff;
        gnd_prev_ff <= gnd_s2_ff;
        irq_s1_ff <= interrogation_in;
        irq_s2_ff <= irq_s1_ff;
        irq_prev_ff <= irq_s2_ff;
        if (settle_ff != 2'h3)
            settle_ff <= settle_ff + 2'h1;
    end
end
// reset level of the stages is a guess; ignore ground-to-air edges until the pin has passed through
wire went_air = gnd_prev_ff && !gnd_s2_ff && (settle_ff == 2'h3);
wire went_gnd = !gnd_prev_ff && gnd_s2_ff;
wire irq_rise = irq_s2_ff && !irq_prev_ff;

// --------------------------------------------------------------------
// wishbone slave
// --------------------------------------------------------------------
wire wb_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
wire wb_wr = wb_req && wb_we_in && wb_sel_in[0];
wire key_wr = wb_wr && (wb_adr_in == `TMCC_REG_KEY);
wire [4:0] key = wb_dat_in[4:0];
reg auto_gnd_ff;
reg restore_req_ff;
reg [11:0] act_ff;
reg [11:0] pend_ff;
reg pend_done_ff;

always @(posedge clk_in or negedge rst_b_in)
begin
    if (!rst_b_in)
    begin
        wb_ack_out <= 1'b0;
        wb_dat_out <= 32'h00000000;
    end
    else
    begin
        wb_ack_out <= wb_req;
        case (wb_adr_in)
            `TMCC_REG_CTRL: wb_dat_out <= {30'h0, restore_req_ff, auto_gnd_ff};
            `TMCC_REG_STATUS: wb_dat_out <= {24'h0, menu_level_out, display_white_out,
                identify_indication_out, reply_status_out, 1'b0, mode_out};
            `TMCC_REG_CODE: wb_dat_out <= {8'h00, pend_ff, act_ff};
            `TMCC_REG_ADDR24: wb_dat_out <= {8'h00, ICAO_ADDR};
            default: wb_dat_out <= 32'h00000000;
        endcase
    end
end

// --------------------------------------------------------------------
// mode control
// --------------------------------------------------------------------
reg [11:0] vfr_prev_ff;
reg vfr_on_ff;
reg [1:0] cur_ff; // entry cursor digit
reg [1:0] ent_ff; // 0 idle, 1 keypad, 2 knob typing, 3 knob done
reg [5:0] ent_tmr_ff;
reg [5:0] menu_tmr_ff;
reg [4:0] ident_tmr_ff;
reg [1:0] sq_tmr_ff;
reg rs_tmr_ff;

localparam [1:0] ENT_IDLE = 2'h0;
localparam [1:0] ENT_KEYPAD = 2'h1;
localparam [1:0] ENT_KNOB = 2'h2;
localparam [1:0] ENT_KNOB_DONE = 2'h3;
localparam [1:0] MENU_TOP = 2'h0;
localparam [1:0] MENU_MODE = 2'h1;
localparam [1:0] MENU_CODE = 2'h2;

// retained mode caught one cycle after release
always @(posedge clk_in or negedge rst_b_in)
begin
    if (!rst_b_in)
    begin
        restore_req_ff <= 1'b1;
        auto_gnd_ff <= 1'b1;
        mode_out <= `TMCC_MODE_STANDBY_KEY;
    end
    else if (restore_req_ff)
    begin
        restore_req_ff <= 1'b0;
        mode_out <= retained_mode_in;
    end
    else if (key_wr && menu_level_out != MENU_TOP && key == `TMCC_KEY_STANDBY)
    begin
        mode_out <= `TMCC_MODE_STANDBY_KEY;
        auto_gnd_ff <= 1'b0;
    end
    else if (key_wr && menu_level_out != MENU_TOP && key == `TMCC_KEY_ON)
    begin
        mode_out <= `TMCC_MODE_ON;
        auto_gnd_ff <= 1'b0;
    end
    else if (key_wr && menu_level_out != MENU_TOP && key == `TMCC_KEY_ALT)
    begin
        mode_out <= `TMCC_MODE_ALT;
        auto_gnd_ff <= 1'b0;
    end
    else if (key_wr && key == `TMCC_KEY_GND && mode_out == `TMCC_MODE_STANDBY_KEY && gnd_s2_ff)
    begin
        mode_out <= `TMCC_MODE_GND;
        auto_gnd_ff <= 1'b1;
    end
    else if (went_air)
    begin
        mode_out <= `TMCC_MODE_ALT;
        auto_gnd_ff <= 1'b1;
    end
    else if (went_gnd && auto_gnd_ff)
        mode_out <= `TMCC_MODE_GND;
end

// --------------------------------------------------------------------
// menu, code entry and timers
// --------------------------------------------------------------------
wire lower = (menu_level_out != MENU_TOP);
wire is_digit = (key <= `TMCC_KEY_DIGIT7);
wire ident_ok = key_wr && key == `TMCC_KEY_IDENT && mode_out != `TMCC_MODE_STANDBY_KEY;

always @(posedge clk_in or negedge rst_b_in)
begin
    if (!rst_b_in)
    begin
        menu_level_out <= MENU_TOP;
        menu_tmr_ff <= 6'h00;
        act_ff <= 12'h000;
        pend_ff <= 12'h000;
        vfr_prev_ff <= 12'h000;
        vfr_on_ff <= 1'b0;
        cur_ff <= 2'h0;
        ent_ff <= ENT_IDLE;
        ent_tmr_ff <= 6'h00;
        ident_tmr_ff <= 5'h00;
        ident_tx_out <= 1'b0;
    end
    else
    begin
        ident_tx_out <= ident_ok;
        if (ident_ok)
            ident_tmr_ff <= `TMCC_IDENT_S;
        else if (sec_tick_ff && ident_tmr_ff != 5'h00)
            ident_tmr_ff <= ident_tmr_ff - 5'h01;
        if (key_wr)
        begin
            menu_tmr_ff <= 6'h00;
            case (key)
                `TMCC_KEY_MENU: if (menu_level_out == MENU_TOP) menu_level_out <= MENU_MODE;
                `TMCC_KEY_CODE: if (menu_level_out == MENU_MODE) menu_level_out <= MENU_CODE;
                `TMCC_KEY_BACK: if (lower) menu_level_out <= menu_level_out - 2'h1;
                `TMCC_KEY_IDENT: menu_level_out <= MENU_TOP;
                default: ;
            endcase
        end
        else if (sec_tick_ff && lower)
        begin
            if (menu_tmr_ff == `TMCC_MENU_TIMEOUT_S - 1)
                menu_level_out <= MENU_TOP;
            else
                menu_tmr_ff <= menu_tmr_ff + 6'h01;
        end
        if (key_wr && key == `TMCC_KEY_VFR && menu_level_out == MENU_MODE)
        begin
            vfr_on_ff <= !vfr_on_ff;
            act_ff <= vfr_on_ff ? vfr_prev_ff : VFR_CODE;
            pend_ff <= vfr_on_ff ? vfr_prev_ff : VFR_CODE;
            if (!vfr_on_ff)
                vfr_prev_ff <= act_ff;
            ent_ff <= ENT_IDLE;
        end
        else if (key_wr && menu_level_out == MENU_CODE && is_digit && ent_ff != ENT_KNOB
            && ent_ff != ENT_KNOB_DONE)
        begin
            if (ent_ff == ENT_IDLE)
                pend_ff <= {key[2:0], act_ff[8:0]};
            else
                case (cur_ff)
                    2'h0: pend_ff[11:9] <= key[2:0];
                    2'h1: pend_ff[8:6] <= key[2:0];
                    2'h2: pend_ff[5:3] <= key[2:0];
                    default: pend_ff[2:0] <= key[2:0];
                endcase
            ent_ff <= ENT_KEYPAD;
            ent_tmr_ff <= 6'h00;
            if (ent_ff == ENT_IDLE)
                cur_ff <= 2'h1;
            else if (cur_ff != 2'h3)
                cur_ff <= cur_ff + 2'h1;
        end
        else if (key_wr && key == `TMCC_KEY_DIGIT_BACK && ent_ff == ENT_KEYPAD && cur_ff != 2'h0)
        begin
            cur_ff <= cur_ff - 2'h1;
            ent_tmr_ff <= 6'h00;
        end
        else if (key_wr && menu_level_out == MENU_CODE && key == `TMCC_KEY_KNOB_DIGIT
            && ent_ff != ENT_KEYPAD && ent_ff != ENT_KNOB_DONE)
        begin
            if (ent_ff == ENT_IDLE)
                pend_ff <= act_ff;
            case (cur_ff)
                2'h0: pend_ff[11:9] <= wb_dat_in[10:8];
                2'h1: pend_ff[8:6] <= wb_dat_in[10:8];
                2'h2: pend_ff[5:3] <= wb_dat_in[10:8];
                default: pend_ff[2:0] <= wb_dat_in[10:8];
            endcase
            ent_ff <= ENT_KNOB;
        end
        else if (key_wr && key == `TMCC_KEY_KNOB_NEXT && ent_ff == ENT_KNOB)
            cur_ff <= cur_ff + 2'h1;
        else if (key_wr && key == `TMCC_KEY_CONFIRM && ent_ff == ENT_KNOB)
        begin
            ent_ff <= ENT_KNOB_DONE;
            ent_tmr_ff <= 6'h00;
        end
        else if (key_wr && ent_ff == ENT_KNOB && (key == `TMCC_KEY_CANCEL || key == `TMCC_KEY_KNOB_PRESS))
        begin
            pend_ff <= act_ff;
            ent_ff <= ENT_IDLE;
            cur_ff <= 2'h0;
        end
        else if (sec_tick_ff && ent_ff != ENT_IDLE && ent_ff != ENT_KNOB)
        begin
            ent_tmr_ff <= ent_tmr_ff + 6'h01;
            if (ent_ff == ENT_KEYPAD && cur_ff == 2'h3 && pend_done_ff
                && ent_tmr_ff == `TMCC_KEYPAD_ACT_S - 1)
            begin
                act_ff <= pend_ff;
                ent_ff <= ENT_IDLE;
                cur_ff <= 2'h0;
            end
            else if (ent_ff == ENT_KEYPAD && !pend_done_ff && ent_tmr_ff == `TMCC_DIGIT_TIMEOUT_S - 1)
            begin
                pend_ff <= act_ff;
                ent_ff <= ENT_IDLE;
                cur_ff <= 2'h0;
            end
            else if (ent_ff == ENT_KNOB_DONE && ent_tmr_ff == `TMCC_KNOB_ACT_S - 1)
            begin
                act_ff <= pend_ff;
                ent_ff <= ENT_IDLE;
                cur_ff <= 2'h0;
            end
        end
    end
end

// fourth keypad digit seen; cleared on any cursor move back
always @(posedge clk_in or negedge rst_b_in)
begin
    if (!rst_b_in)
        pend_done_ff <= 1'b0;
    else if (ent_ff == ENT_IDLE)
        pend_done_ff <= 1'b0;
    else if (key_wr && ent_ff == ENT_KEYPAD && is_digit && menu_level_out == MENU_CODE)
        pend_done_ff <= (cur_ff == 2'h3);
    else if (key_wr && key == `TMCC_KEY_DIGIT_BACK)
        pend_done_ff <= 1'b0;
end

// --------------------------------------------------------------------
// replies and squitter
// --------------------------------------------------------------------
reg reply_ok;
always @*
begin
    case (mode_out)
        `TMCC_MODE_GND: reply_ok = interrogation_type_in[1];
        `TMCC_MODE_STANDBY_KEY: reply_ok = 1'b0;
        `TMCC_MODE_ON: reply_ok = (interrogation_type_in != `TMCC_REQ_MODE_C);
        default: reply_ok = 1'b1;
    endcase
end

assign squitter_addr_out = ICAO_ADDR;
assign display_white_out = (mode_out == `TMCC_MODE_STANDBY_KEY);

always @(posedge clk_in or negedge rst_b_in)
begin
    if (!rst_b_in)
    begin
        reply_valid_out <= 1'b0;
        reply_type_out <= 2'h0;
        reply_alt_out <= 13'h0000;
        reply_code_out <= 12'h000;
        reply_has_alt_out <= 1'b0;
        squitter_out <= 1'b0;
        sq_tmr_ff <= 2'h0;
        rs_tmr_ff <= 1'b0;
        reply_status_out <= 1'b0;
        identify_indication_out <= 1'b0;
    end
    else
    begin
        identify_indication_out <= (ident_tmr_ff != 5'h00);
        reply_valid_out <= irq_rise && reply_ok;
        if (irq_rise && reply_ok)
        begin
            reply_type_out <= interrogation_type_in;
            reply_code_out <= act_ff;
            reply_has_alt_out <= (mode_out == `TMCC_MODE_ALT) && interrogation_type_in[0];
            reply_alt_out <= (mode_out == `TMCC_MODE_ALT) ? pressure_alt_in : 13'h0000;
        end
        squitter_out <= 1'b0;
        if (sec_tick_ff)
        begin
            squitter_out <= (sq_tmr_ff == `TMCC_SQUITTER_S - 1);
            sq_tmr_ff <= (sq_tmr_ff == `TMCC_SQUITTER_S - 1) ? 2'h0 : sq_tmr_ff + 2'h1;
        end
        if (irq_rise && reply_ok)
        begin
            reply_status_out <= 1'b1;
            rs_tmr_ff <= 1'b0;
        end
        else if (sec_tick_ff && reply_status_out)
        begin
            if (rs_tmr_ff)
                reply_status_out <= 1'b0;
            rs_tmr_ff <= 1'b1;
        end
    end
end

endmodule
